// File: rtl/ppr_consts.svh
// constants for the peripheral pin remap arbiter: sizes, offsets, reset values, keys
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH

// pin and function counts
`define PPR_NUM_IO        8
`define PPR_NUM_PINS      12
`define PPR_NUM_IN_FUNCS  8
`define PPR_PIN_SEL_W     4
`define PPR_CODE_W        3

// selector codes
`define PPR_PIN_NONE      4'hF
`define PPR_CODE_NULL     3'h0

// register byte offsets
`define PPR_OFF_LATCH     12'h000
`define PPR_OFF_DIR       12'h004
`define PPR_OFF_ANALOG    12'h008
`define PPR_OFF_PINSTATE  12'h00C
`define PPR_OFF_LOCK      12'h010
`define PPR_IN_MAP_PAGE   7'h01
`define PPR_OUT_MAP_PAGE  7'h02

// reset values
`define PPR_RST_LATCH     8'h00
`define PPR_RST_DIR       8'hFF
`define PPR_RST_ANALOG    12'hFFF

// unlock keys
`define PPR_KEY1          32'h0000_0055
`define PPR_KEY2          32'h0000_00AA

`endif

// File: rtl/ppr_pkg.sv
// types shared by the peripheral pin remap arbiter
`include "ppr_consts.svh"
package ppr_pkg;
  typedef logic [`PPR_PIN_SEL_W-1:0] ppr_pin_sel_t;
  typedef logic [`PPR_CODE_W-1:0]    ppr_out_code_t;
  typedef enum logic [1:0] {
    PPR_LK_OPEN,
    PPR_LK_LOCKED,
    PPR_LK_KEY1
  } ppr_lock_e;
endpackage

// File: rtl/ppr_pin_cell.sv
// output arbitration for one remappable i/o pin
`timescale 1ns/1ns
`default_nettype none
`include "ppr_consts.svh"
module ppr_pin_cell
  import ppr_pkg::*;
(
  // dedicated functions on this pin
  input  wire logic          ded_oe,
  input  wire logic          ded_val,
  input  wire logic          ana_busy,
  // remapped output selection
  input  wire ppr_out_code_t code,
  input  wire logic [7:1]    remap_vals,
  // general purpose port
  input  wire logic          dir_in,
  input  wire logic          latch,
  // resulting drive
  output logic               drv_out,
  output logic               drv_oe
);

  // priority: dedicated, then remapped, then port latch gated by direction
  always_comb begin
    drv_out = 1'b0;
    drv_oe  = 1'b0;
    if (ded_oe) begin
      drv_out = ded_val;
      drv_oe  = 1'b1;
    end else if (code != `PPR_CODE_NULL && !ana_busy) begin
      drv_out = remap_vals[code];
      drv_oe  = 1'b1; // overrides direction
    end else if (!dir_in) begin
      drv_out = latch;
      drv_oe  = 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: rtl/ppr_top.sv
// peripheral pin remap arbiter: apb registers, input routing, pin output arbitration
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ppr_consts.svh"
module ppr_top
  import ppr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pads (pins 0..7 remappable_io_pin, 8..11 remappable_input_only_pin)
  input  wire logic [11:0] pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  // dedicated functions
  input  wire logic [7:0]  ded_out_en,
  input  wire logic [7:0]  ded_out_val,
  input  wire logic [11:0] ded_analog_en,
  // remappable peripheral side
  input  wire logic [7:1]  remap_out_val,
  output logic      [7:0]  remap_in,
  output logic      [11:0] pin_digital_in
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic          [7:0]  latch;
  logic          [7:0]  dir;
  logic          [11:0] ana_sel;
  ppr_pin_sel_t         in_map  [`PPR_NUM_IN_FUNCS];
  ppr_out_code_t        out_map [`PPR_NUM_IO];
  ppr_lock_e            lock_state;
  logic          [11:0] pin_meta;
  logic          [11:0] pin_sync;
  logic          [11:0] dig_in_en;
  logic          [7:0]  next_pin_out;
  logic          [7:0]  next_pin_oe;
  logic          [31:0] next_prdata;
  logic                 next_err;
  logic                 pend;
  logic                 wr_fire;
  logic                 hit_in_map;
  logic                 hit_out_map;
  logic          [2:0]  map_idx;
  logic                 remap_val1;

  // pick one synced pin, or zero for a selector that names no pin
  function automatic logic pick_pin(input logic [11:0] vals, input ppr_pin_sel_t sel);
    logic res;
    res = 1'b0;
    if (sel < ppr_pin_sel_t'(`PPR_NUM_PINS)) begin
      res = vals[sel];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign pend        = psel & penable & ~pready;
  assign wr_fire     = psel & penable & pready & pwrite;
  assign hit_in_map  = (paddr[11:5] == `PPR_IN_MAP_PAGE) && (paddr[1:0] == 2'h0);
  assign hit_out_map = (paddr[11:5] == `PPR_OUT_MAP_PAGE) && (paddr[1:0] == 2'h0);
  assign map_idx     = paddr[4:2];

  // read data and error for the access in progress
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (hit_in_map) begin
      next_prdata = {28'h000_0000, in_map[map_idx]};
      next_err    = pwrite && (lock_state != PPR_LK_OPEN);
    end else if (hit_out_map) begin
      next_prdata = {29'h0000_0000, out_map[map_idx]};
      next_err    = pwrite && (lock_state != PPR_LK_OPEN);
    end else begin
      case (paddr)
        `PPR_OFF_LATCH:    next_prdata = {24'h00_0000, latch};
        `PPR_OFF_DIR:      next_prdata = {24'h00_0000, dir};
        `PPR_OFF_ANALOG:   next_prdata = {20'h0_0000, ana_sel};
        `PPR_OFF_PINSTATE: next_prdata = {20'h0_0000, pin_sync};
        `PPR_OFF_LOCK:     next_prdata = {31'h0000_0000, lock_state != PPR_LK_OPEN};
        default:           next_err    = 1'b1;
      endcase
    end
  end

  // one wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= pend;
      if (pend) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_err;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port registers

  // latch, direction and analog select are never locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch   <= `PPR_RST_LATCH;
      dir     <= `PPR_RST_DIR;
      ana_sel <= `PPR_RST_ANALOG;
    end else if (wr_fire) begin
      case (paddr)
        `PPR_OFF_LATCH:  latch   <= pwdata[7:0];
        `PPR_OFF_DIR:    dir     <= pwdata[7:0];
        `PPR_OFF_ANALOG: ana_sel <= pwdata[11:0];
        default:         ana_sel <= ana_sel;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mapping lock: set by writing 1, cleared only by two keys back to back

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_state <= PPR_LK_OPEN;
    end else if (wr_fire && paddr == `PPR_OFF_LOCK) begin
      case (lock_state)
        PPR_LK_OPEN:   lock_state <= pwdata[0] ? PPR_LK_LOCKED : PPR_LK_OPEN;
        PPR_LK_LOCKED: lock_state <= (pwdata == `PPR_KEY1) ? PPR_LK_KEY1 : PPR_LK_LOCKED;
        PPR_LK_KEY1:   lock_state <= (pwdata == `PPR_KEY2) ? PPR_LK_OPEN : PPR_LK_LOCKED;
        default:       lock_state <= PPR_LK_LOCKED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mapping selectors, one set per direction

  // input selectors hold a pin number; reset leaves every input unconnected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PPR_NUM_IN_FUNCS; i++) begin
        in_map[i] <= `PPR_PIN_NONE;
      end
    end else if (wr_fire && hit_in_map && lock_state == PPR_LK_OPEN) begin
      in_map[map_idx] <= pwdata[`PPR_PIN_SEL_W-1:0];
    end
  end

  // output selectors hold a function code per pin; null means no remapped output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PPR_NUM_IO; i++) begin
        out_map[i] <= `PPR_CODE_NULL;
      end
    end else if (wr_fire && hit_out_map && lock_state == PPR_LK_OPEN) begin
      out_map[map_idx] <= pwdata[`PPR_CODE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pad input path

  // two stage synchroniser; only pin_sync is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 12'h000;
      pin_sync <= 12'h000;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // buffer enable ignores dir on purpose; analog of any kind shuts it
  assign dig_in_en = ~ana_sel & ~ded_analog_en;

  // gated pin levels for dedicated inputs and remapped input routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_digital_in <= 12'h000;
      remap_in       <= 8'h00;
    end else begin
      pin_digital_in <= pin_sync & dig_in_en;
      for (int i = 0; i < `PPR_NUM_IN_FUNCS; i++) begin
        // any number of inputs may name one pin, whatever drives it
        remap_in[i] <= pick_pin(pin_sync & dig_in_en, in_map[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pad output path

  for (genvar p = 0; p < `PPR_NUM_IO; p++) begin : g_pin
    ppr_pin_cell u_cell (
      .ded_oe     (ded_out_en[p]),
      .ded_val    (ded_out_val[p]),
      .ana_busy   (ded_analog_en[p]),
      .code       (out_map[p]),
      .remap_vals (remap_out_val),
      .dir_in     (dir[p]),
      .latch      (latch[p]),
      .drv_out    (next_pin_out[p]),
      .drv_oe     (next_pin_oe[p])
    );
  end

  // registered pads; a single mux per pin so only one source ever drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_map_write_locked;
    wr_fire && hit_in_map && map_idx == 3'h0 && lock_state != PPR_LK_OPEN;
  endsequence

  sequence s_input_open(int p);
    !ana_sel[p] && !ded_analog_en[p];
  endsequence

  property p_ded_prio;
    @(posedge pclk) disable iff (!presetn)
      ded_out_en[0] |=> pin_oe[0] && pin_out[0] == $past(ded_out_val[0]);
  endproperty
  a_ded_prio: assert property (p_ded_prio)
    else $error("dedicated output lost priority");

  // level of the function mapped to pin 1, held as a net so its past can be taken
  assign remap_val1 = remap_out_val[out_map[1]];

  property p_remap_drive;
    @(posedge pclk) disable iff (!presetn)
      (!ded_out_en[1] && out_map[1] != 3'h0 && !ded_analog_en[1])
        |=> pin_oe[1] && pin_out[1] == $past(remap_val1);
  endproperty
  a_remap_drive: assert property (p_remap_drive)
    else $error("remapped output not driving pin");

  property p_dir_gate;
    @(posedge pclk) disable iff (!presetn)
      (!ded_out_en[0] && out_map[0] == 3'h0 && dir[0]) |=> !pin_oe[0];
  endproperty
  a_dir_gate: assert property (p_dir_gate)
    else $error("pin driven while direction is input");

  property p_latch_drive;
    @(posedge pclk) disable iff (!presetn)
      (!ded_out_en[2] && out_map[2] == 3'h0 && !dir[2])
        |=> pin_oe[2] && pin_out[2] == $past(latch[2]);
  endproperty
  a_latch_drive: assert property (p_latch_drive)
    else $error("port latch not driving pin");

  property p_analog_blocks;
    @(posedge pclk) disable iff (!presetn)
      (ded_analog_en[3] || ana_sel[3]) |=> !pin_digital_in[3];
  endproperty
  a_analog_blocks: assert property (p_analog_blocks)
    else $error("digital input seen on analog pin");

  property p_input_follows;
    @(posedge pclk) disable iff (!presetn)
      s_input_open(4) |=> pin_digital_in[4] == $past(pin_sync[4]);
  endproperty
  a_input_follows: assert property (p_input_follows)
    else $error("digital input not following pin");

  property p_reset_analog;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> ana_sel == 12'hFFF && pin_digital_in == 12'h000;
  endproperty
  a_reset_analog: assert property (p_reset_analog)
    else $error("analog select not set after reset");

  property p_lock_holds;
    @(posedge pclk) disable iff (!presetn)
      s_map_write_locked |=> $stable(in_map[0]);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("mapping changed while locked");

  property p_null_input;
    @(posedge pclk) disable iff (!presetn)
      (in_map[5] == 4'hF) [*2] |-> !remap_in[5];
  endproperty
  a_null_input: assert property (p_null_input)
    else $error("unconnected input not zero");

  property p_shared_input;
    @(posedge pclk) disable iff (!presetn)
      (in_map[6] == in_map[7]) |=> remap_in[6] == remap_in[7];
  endproperty
  a_shared_input: assert property (p_shared_input)
    else $error("inputs on one pin disagree");

  property p_analog_no_remap;
    @(posedge pclk) disable iff (!presetn)
      (ded_analog_en[1] && !ded_out_en[1] && dir[1]) |=> !pin_oe[1];
  endproperty
  a_analog_no_remap: assert property (p_analog_no_remap)
    else $error("remapped output drove an analog pin");

endmodule
`default_nettype wire

// File: bench/ppr_far_model.sv
// far side of the arbiter: pads with external drivers and remappable peripherals
`timescale 1ns/1ns
`default_nettype none
module ppr_far_model (
  // levels set by the bench
  input  wire logic [11:0] ext_lvl,
  input  wire logic [7:1]  periph_val,
  // arbiter pad drive
  input  wire logic [7:0]  pin_out,
  input  wire logic [7:0]  pin_oe,
  // toward the arbiter
  output logic      [11:0] pin_in,
  output logic      [7:1]  remap_out_val
);
  // the external source yields while the pad drives, so one driver per pin
  always_comb begin
    pin_in        = ext_lvl;
    remap_out_val = periph_val;
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/test_ppr_top.sv
// self-checking bench for the peripheral pin remap arbiter
`timescale 1ns/1ns
`default_nettype none
`include "ppr_consts.svh"
module test_ppr_top;
  import ppr_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, ext_lvl = 12'hA5C, ded_analog_en = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er;
  logic [11:0] pin_in, pin_digital_in;
  logic [7:0]  pin_out, pin_oe, remap_in, ded_out_en = 0, ded_out_val = 0;
  logic [7:1]  periph_val = 0, remap_out_val;
  int          errors = 0, tests_run = 0;
  always #25 pclk = ~pclk;
  ppr_top i_ppr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .ded_out_en(ded_out_en), .ded_out_val(ded_out_val), .ded_analog_en(ded_analog_en),
    .remap_out_val(remap_out_val), .remap_in(remap_in), .pin_digital_in(pin_digital_in));
  ppr_far_model i_ppr_far_model (.ext_lvl(ext_lvl), .periph_val(periph_val),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .remap_out_val(remap_out_val));
  ////////////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready wait", 0, 1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1, a, d);
    chk("write error", er, e);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(0, a, 0);
    chk("read data", rd, exp);
    chk("read error", er, e);
  endtask
  task automatic stop_test;
    $display("counts: %0d checks, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values; analog selected and inputs dead although pads are active
  task automatic t_reset;
    rdchk(`PPR_OFF_LATCH, 32'h0000_0000, 0);
    rdchk(`PPR_OFF_DIR, 32'h0000_00FF, 0);
    rdchk(`PPR_OFF_ANALOG, 32'h0000_0FFF, 0);
    rdchk(`PPR_OFF_LOCK, 32'h0000_0000, 0);
    rdchk(12'h020, 32'h0000_000F, 0);
    rdchk(`PPR_OFF_PINSTATE, 32'h0000_0A5C, 0);
    chk("digital in", pin_digital_in, 0);
    chk("remap in", remap_in, 0);
    chk("pad enable", pin_oe, 0);
    $display("test reset done");
  endtask
  // input buffer gated by analog select, not by direction
  task automatic t_input_gate;
    wr(`PPR_OFF_ANALOG, 0, 0);
    cyc(5);
    chk("digital in", pin_digital_in, 12'hA5C);
    wr(`PPR_OFF_DIR, 32'h0000_0000, 0);
    cyc(5);
    chk("digital in", pin_digital_in, 12'hA00);
    ded_analog_en <= 12'h808;
    cyc(5);
    chk("digital in", pin_digital_in, 12'h200);
    ded_analog_en <= 0;
    wr(`PPR_OFF_DIR, 32'h0000_00FF, 0);
    $display("test input gate done");
  endtask
  // several inputs on one pin, input beside a dedicated output
  task automatic t_in_map;
    ded_out_en <= 8'h01;
    ded_out_val <= 8'h01;
    ded_analog_en <= 12'h800;
    wr(12'h020, 9, 0);
    wr(12'h024, 9, 0);
    wr(12'h028, 0, 0);
    wr(12'h02C, 11, 0);
    wr(12'h038, 9, 0);
    wr(12'h03C, 9, 0);
    cyc(5);
    chk("remap in", remap_in, 8'hC7);
    ded_out_en <= 0;
    ded_analog_en <= 0;
    $display("test input map done");
  endtask
  // output arbitration among dedicated, remapped and port sources
  task automatic t_out_prio;
    periph_val <= 7'b000_0100;
    wr(12'h044, 3, 0);
    wr(12'h048, 3, 0);
    cyc(3);
    chk("pad enable", pin_oe, 8'h06);
    chk("pad value", pin_out & pin_oe, 8'h06);
    rdchk(12'h044, 32'h0000_0003, 0);
    ded_out_en <= 8'h04;
    ded_out_val <= 8'h00;
    ded_analog_en <= 12'h002;
    cyc(3);
    chk("pad enable", pin_oe, 8'h04);
    chk("pad value", pin_out & pin_oe, 8'h00);
    wr(`PPR_OFF_LATCH, 32'h0000_0002, 0);
    wr(`PPR_OFF_DIR, 32'h0000_00FD, 0);
    cyc(3);
    chk("pad enable", pin_oe, 8'h06);
    chk("pad value", pin_out & pin_oe, 8'h02);
    ded_out_en <= 0;
    ded_analog_en <= 0;
    $display("test output priority done");
  endtask
  // mapping lock and its two-key release, plus an unmapped address
  task automatic t_lock;
    wr(`PPR_OFF_LOCK, 1, 0);
    rdchk(`PPR_OFF_LOCK, 1, 0);
    wr(12'h020, 5, 1);
    rdchk(12'h020, 9, 0);
    wr(`PPR_OFF_LOCK, `PPR_KEY1, 0);
    wr(`PPR_OFF_LOCK, 32'h0000_0012, 0);
    rdchk(`PPR_OFF_LOCK, 1, 0);
    wr(`PPR_OFF_LOCK, `PPR_KEY1, 0);
    wr(`PPR_OFF_LOCK, `PPR_KEY2, 0);
    rdchk(`PPR_OFF_LOCK, 0, 0);
    wr(12'h020, 5, 0);
    rdchk(12'h020, 5, 0);
    rdchk(12'h0F0, 0, 1);
    $display("test lock done");
  endtask
  // reset again mid-run with the lock set; analog select, lock, selectors and pad inputs/enables must return to defaults
  task automatic t_rereset;
    wr(`PPR_OFF_LOCK, 1, 0);
    presetn <= 0;
    cyc(2);
    presetn <= 1;
    cyc(1);
    rdchk(`PPR_OFF_ANALOG, 32'h0000_0FFF, 0);
    rdchk(`PPR_OFF_LOCK, 32'h0000_0000, 0);
    rdchk(12'h020, 32'h0000_000F, 0);
    rdchk(12'h044, 32'h0000_0000, 0);
    chk("digital in", pin_digital_in, 0);
    chk("remap in", remap_in, 0);
    chk("pad enable", pin_oe, 0);
    $display("test second reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog well past the expected few hundred cycles
  initial begin
    cyc(5000);
    errors++;
    stop_test();
  end
  initial begin
    cyc(3);
    presetn <= 1;
    cyc(1);
    t_reset();
    t_input_gate();
    t_in_map();
    t_out_prio();
    t_lock();
    t_rereset();
    stop_test();
  end
endmodule
`default_nettype wire
